/* File: seti_consts.vh */
// Constants of the serial EEPROM target interface
`ifndef SETI_CONSTS_VH
`define SETI_CONSTS_VH
// Clock rate of sys_clk in kHz
`define SETI_CLK_KHZ      20000
// Longest program cycle in microseconds
`define SETI_TWC_US       5000
// Address word layout
`define SETI_DEV_TYPE_MSB 7
`define SETI_DEV_TYPE_LSB 4
`define SETI_SEL_MSB      3
`define SETI_SEL_LSB      1
`define SETI_RW_BIT       0
// Bits per byte and ack slot count
`define SETI_BITS         4'h8
// Page size in bytes
`define SETI_PAGE_BYTES   8'h80
// Program FIFO shape: page base, offset, data
`define SETI_FIFO_WIDTH   24
`define SETI_FIFO_DEPTH   8
`define SETI_FIFO_AW      3
// Reset values
`define SETI_ADDR_RST     16'h0000
`define SETI_BYTE_RST     8'h00
`endif

/* File: seti_fifo.v */
// Small valid/ready FIFO between page buffer and memory port
`timescale 1ns/1ps
module seti_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             sys_clk,
  input  wire             rst_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage words
  reg [AW-1:0]    wr_ptr;          // Next slot to fill
  reg [AW-1:0]    rd_ptr;          // Next slot to drain
  reg [AW:0]      count;           // Words held
  wire            push;
  wire            pop;

  // Honest full and empty flags
  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Data words carry no reset; only pointers and count need one
  always @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap by masking; depth is a power of two
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // seti_fifo

/* File: seti_target.v */
// Two-wire serial target front end of a byte-wide EEPROM
// Operation
// - Sample SDA on SCL rise, drive after fall
// - SDA is open drain, low or released
// - SDA fall with SCL high is start
// - SDA rise with SCL high is stop
// - Stop after write data launches program cycle
// - Eight-bit words, ninth clock carries acknowledge
// - Read: host ack continues, no-ack ends
// - No ack nor stop: stay released
// - Address word: type, select, direction
// - Ack only on type and strap match
// - Direction bit low writes, high reads
// - Straps pulled low, eight devices per bus
// - Write: two address bytes, then data, acked
// - Program cycle refuses new transactions
// - Page write buffers up to 128 bytes
// - Page offset wraps within the page
// - Inhibit high: addresses acked, data refused
// - Inhibit low writes allowed; reads always work
// - Polling: no-ack while busy, ack after
// - Program cycle lasts the maximum time, longer if the page drain lags
// - Read returns counter data, MSB first
// - Random read: dummy write, repeated start
// - Sequential read wraps over whole array
`timescale 1ns/1ps
`include "seti_consts.vh"
module seti_target #(
  // Device type code; the value is arbitrary
  parameter [3:0]  DEV_TYPE  = 4'h5,
  // Program time in sys_clk cycles, shorten for simulation
  parameter [16:0] WC_CYCLES = `SETI_TWC_US * (`SETI_CLK_KHZ / 1000)
) (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        scl,
  input  wire        sda_in,
  output wire        sda_out,
  output reg         sda_oe,
  input  wire [2:0]  chip_select_straps,
  input  wire        write_inhibit_pin,
  output reg  [15:0] mem_addr,
  output reg  [7:0]  mem_wdata,
  output reg         mem_we,
  input  wire        mem_ready,
  input  wire [7:0]  mem_rdata,
  output reg         prog_busy
);
  // Protocol states
  localparam [2:0] S_IDLE = 3'h0; // Standby, waits for a start
  localparam [2:0] S_DEV  = 3'h1; // Receiving address word
  localparam [2:0] S_AHI  = 3'h2; // Receiving high address byte
  localparam [2:0] S_ALO  = 3'h3; // Receiving low address byte
  localparam [2:0] S_WDAT = 3'h4; // Receiving write data
  localparam [2:0] S_RDAT = 3'h5; // Sending read data

  // Input synchronisers, two stages each
  reg        scl_m;
  reg        scl_s;
  reg        scl_d;       // Previous synchronised SCL
  reg        sda_m;
  reg        sda_s;
  reg        sda_d;       // Previous synchronised SDA
  reg        wp_m;
  reg        wp_s;
  reg  [2:0] cs_m;
  reg  [2:0] cs_s;

  // Protocol engine
  reg  [2:0] state;
  reg  [3:0] bit_cnt;     // Bits of the current byte seen
  reg        ack_ph;      // Inside the ninth clock
  reg        acked;       // Our answer in this ninth clock
  reg        host_nack;   // Host answer after a read byte
  reg  [7:0] shreg;       // Incoming byte
  reg  [7:0] tx;          // Outgoing byte, top bit next
  reg  [15:0] addr;       // Internal address counter
  reg        wr_pend;     // Accepted data awaits a stop

  // Page buffer and its valid flags
  reg  [7:0]   page_data_byte [0:127];
  reg  [127:0] pvalid;

  // Program cycle walker and timer
  reg  [7:0]  walk_idx;
  reg         walk_on;
  reg  [16:0] timer;

  // FIFO hookup
  wire        fifo_in_valid;
  wire        fifo_in_ready;
  wire [23:0] fifo_in_data;
  wire        fifo_out_valid;
  wire [23:0] fifo_out_data;

  // Bus events seen by sys_clk
  wire scl_rise;
  wire scl_fall;
  wire start_c;
  wire stop_c;
  wire dev_match;

  // Next offset inside the current page, wrapping at its end
  function [15:0] seti_page_inc;
    input [15:0] a;
    begin
      seti_page_inc = {a[15:7], a[6:0] + 7'h01};
    end
  endfunction

  // open drain
  // Output level is always low; only the enable moves
  assign sda_out = 1'b0;

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_c  = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c   = scl_s & scl_d & ~sda_d & sda_s;

  // word layout
  // Type code on top, strap code next, direction in bit zero
  // address match
  // Busy also refuses the word, which serves polling as well
  assign dev_match =
    (shreg[`SETI_DEV_TYPE_MSB:`SETI_DEV_TYPE_LSB] == DEV_TYPE) &&
    (shreg[`SETI_SEL_MSB:`SETI_SEL_LSB] == cs_s) && !prog_busy;

  // page drain
  // Walker offers each buffered byte with its full address
  assign fifo_in_valid = walk_on && !walk_idx[7] &&
                         pvalid[walk_idx[6:0]];
  assign fifo_in_data  = {addr[15:7], walk_idx[6:0],
                          page_data_byte[walk_idx[6:0]]};

  // Buffer between page walker and a memory that may stall
  seti_fifo #(
    .WIDTH (`SETI_FIFO_WIDTH),
    .DEPTH (`SETI_FIFO_DEPTH),
    .AW    (`SETI_FIFO_AW)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (mem_ready),
    .out_data  (fifo_out_data)
  );

  // Synchronisers; pins come from outside this clock's domain
  // strap sampling
  // Straps are pulled low at the pad, so open pins read zero
  // inhibit sampling
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      wp_m  <= 1'b1;
      wp_s  <= 1'b1;
      cs_m  <= 3'h0;
      cs_s  <= 3'h0;
    end else begin
      scl_m <= scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
      wp_m  <= write_inhibit_pin;
      wp_s  <= wp_m;
      cs_m  <= chip_select_straps;
      cs_s  <= cs_m;
    end
  end

  // Memory port: writes from the FIFO, otherwise read address
  // Registered so the array sees clean strobes
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_we    <= 1'b0;
      mem_addr  <= `SETI_ADDR_RST;
      mem_wdata <= `SETI_BYTE_RST;
    end else if (fifo_out_valid && mem_ready) begin
      mem_we    <= 1'b1;
      mem_addr  <= fifo_out_data[23:8];
      mem_wdata <= fifo_out_data[7:0];
    end else begin
      mem_we    <= 1'b0;
      mem_addr  <= addr;
    end
  end

  // Page data storage; no reset needed behind the valid flags
  always @(posedge sys_clk) begin
    if (scl_fall && ack_ph == 1'b0 && bit_cnt == `SETI_BITS &&
        state == S_WDAT && !wp_s) begin
      page_data_byte[addr[6:0]] <= shreg;
    end
  end

  // Main protocol engine, stepped by sampled SCL edges
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= S_IDLE;
      bit_cnt   <= 4'h0;
      ack_ph    <= 1'b0;
      acked     <= 1'b0;
      host_nack <= 1'b1;
      shreg     <= `SETI_BYTE_RST;
      tx        <= `SETI_BYTE_RST;
      addr      <= `SETI_ADDR_RST;
      wr_pend   <= 1'b0;
      pvalid    <= 128'h0;
      sda_oe    <= 1'b0;
      prog_busy <= 1'b0;
      walk_on   <= 1'b0;
      walk_idx  <= 8'h00;
      timer     <= 17'h00000;
    end else begin
      // program timer
      // Timer runs from the stop; busy also waits for walker and FIFO to drain
      if (prog_busy) begin
        if (timer != WC_CYCLES) begin
          timer <= timer + 17'h00001;
        end
        if ((timer >= WC_CYCLES - 17'h00001) && !walk_on &&
            !fifo_out_valid && !mem_we) begin
          prog_busy <= 1'b0;
        end
      end
      // Walker steps over empty slots, waits on a full FIFO
      if (walk_on) begin
        if (walk_idx[7]) begin
          walk_on <= 1'b0;
        end else if (!pvalid[walk_idx[6:0]]) begin
          walk_idx <= walk_idx + 8'h01;
        end else if (fifo_in_ready) begin
          pvalid[walk_idx[6:0]] <= 1'b0;
          walk_idx <= walk_idx + 8'h01;
        end
      end

      if (start_c) begin
        // start begins a word
        // Repeated start drops unfinished write data
        // no program for it
        state   <= S_DEV;
        bit_cnt <= 4'h0;
        ack_ph  <= 1'b0;
        sda_oe  <= 1'b0;
        if (!prog_busy) begin
          wr_pend <= 1'b0;
          pvalid  <= 128'h0;
        end
      end else if (stop_c) begin
        state   <= S_IDLE;
        bit_cnt <= 4'h0;
        ack_ph  <= 1'b0;
        sda_oe  <= 1'b0;
        // launch program
        // Only whole acknowledged bytes set the pending flag
        if (wr_pend && !prog_busy) begin
          wr_pend   <= 1'b0;
          prog_busy <= 1'b1;
          walk_on   <= 1'b1;
          walk_idx  <= 8'h00;
          timer     <= 17'h00000;
        end
      end else if (state == S_IDLE) begin
        // standby
        // Standby ignores SCL until the next start
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (bit_cnt != `SETI_BITS) begin
          bit_cnt <= bit_cnt + 4'h1;
          if (state != S_RDAT) begin
            shreg <= {shreg[6:0], sda_s};
          end
        end else if (state == S_RDAT) begin
          host_nack <= sda_s;
          addr <= addr + 16'h0001;
        end
      end else if (scl_fall) begin
        if (ack_ph) begin
          // End of the ninth clock: release and move on
          ack_ph  <= 1'b0;
          bit_cnt <= 4'h0;
          sda_oe  <= 1'b0;
          case (state)
            S_DEV: begin
              if (!acked) begin
                state <= S_IDLE;
              end else if (shreg[`SETI_RW_BIT]) begin
                state  <= S_RDAT;
                sda_oe <= ~mem_rdata[7];
                tx     <= {mem_rdata[6:0], 1'b1};
              end else begin
                state <= S_AHI;
              end
            end
            S_AHI: begin
              state <= S_ALO;
            end
            S_ALO: begin
              state <= S_WDAT;
            end
            S_WDAT: begin
              state <= acked ? S_WDAT : S_IDLE;
            end
            S_RDAT: begin
              if (host_nack) begin
                state <= S_IDLE;
              end else begin
                sda_oe <= ~mem_rdata[7];
                tx     <= {mem_rdata[6:0], 1'b1};
              end
            end
            default: begin
              state <= S_IDLE;
            end
          endcase
        end else if (bit_cnt == `SETI_BITS) begin
          ack_ph <= 1'b1;
          case (state)
            S_DEV: begin
              acked  <= dev_match;
              sda_oe <= dev_match;
            end
            S_AHI: begin
              addr[15:8] <= shreg;
              acked      <= 1'b1;
              sda_oe     <= 1'b1;
            end
            S_ALO: begin
              addr[7:0] <= shreg;
              acked     <= 1'b1;
              sda_oe    <= 1'b1;
            end
            S_WDAT: begin
              acked  <= !wp_s;
              sda_oe <= !wp_s;
              if (!wp_s) begin
                pvalid[addr[6:0]] <= 1'b1;
                wr_pend <= 1'b1;
                addr <= seti_page_inc(addr);
              end
            end
            default: begin
              acked  <= 1'b0;
              sda_oe <= 1'b0;
            end
          endcase
        end else if (state == S_RDAT) begin
          sda_oe <= ~tx[7];
          tx     <= {tx[6:0], 1'b1};
        end
      end
    end
  end
endmodule // seti_target

/* File: seti_monitor.sv */
// Port checks for the serial EEPROM target interface
`timescale 1ns/1ps
module seti_monitor #(
  parameter [3:0]  DEV_TYPE  = 4'h5,
  parameter [16:0] WC_CYCLES = 17'd200
) (
  input wire        sys_clk,
  input wire        rst_n,
  input wire        scl,
  input wire        sda_out,
  input wire        sda_oe,
  input wire        write_inhibit_pin,
  input wire        mem_we,
  input wire        mem_ready,
  input wire        prog_busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  reg [16:0] busy_all;  // Cycles of the current program cycle
  reg [16:0] busy_rdy;  // Of those, cycles with the memory willing
  // Stall-free busy time bounds the program cycle despite slow memory
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_all <= 17'h0;
      busy_rdy <= 17'h0;
    end else if (!prog_busy) begin
      busy_all <= 17'h0;
      busy_rdy <= 17'h0;
    end else begin
      busy_all <= busy_all + 17'h1;
      busy_rdy <= busy_rdy + {16'h0, mem_ready};
    end
  end
  // A driven bit stands for three more cycles after it rises, past the next clock rise
  sequence s_hold;
    sda_oe [*3];
  endsequence
  a_drive_low_only: assert property (sda_out == 1'b0)
    else $error("data output not low");
  a_change_scl_low: assert property ($changed(sda_oe) |-> !scl)
    else $error("data drive changed with clock high");
  a_ack_hold: assert property ($rose(sda_oe) |=> s_hold)
    else $error("driven bit did not stand");
  a_busy_quiet: assert property (prog_busy |-> !sda_oe)
    else $error("bus driven during program cycle");
  a_write_in_busy: assert property (mem_we |-> $past(prog_busy))
    else $error("memory write outside program cycle");
  a_write_ready: assert property (mem_we |-> $past(mem_ready))
    else $error("memory write without ready");
  a_prog_min: assert property (
    $fell(prog_busy) |-> busy_all >= WC_CYCLES - 17'd2)
    else $error("program cycle too short");
  a_prog_max: assert property (
    prog_busy |-> busy_rdy <= WC_CYCLES + 17'd8)
    else $error("program cycle too long");
  a_inhibit_block: assert property (
    $rose(prog_busy) |-> !$past(write_inhibit_pin, 4))
    else $error("program cycle with writes inhibited");
endmodule // seti_monitor

/* File: seti_host.sv */
// Two-wire bus controller model for the bench
`timescale 1ns/1ps
module seti_host (
  input  wire sys_clk,
  input  wire sda,
  output reg  scl,
  output reg  sda_low
);
  // Idle bus: clock stands high, data left to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Quarter bus period is two system clocks
  task tick(input integer n);
    repeat (n) @(negedge sys_clk);
  endtask
  task bit_io(input b, output s);
    begin
      tick(2);
      sda_low = !b;
      tick(2);
      scl = 1'b1;
      tick(2);
      s = sda;
      tick(2);
      scl = 1'b0;
    end
  endtask
  task start_c;
    begin
      tick(2);
      sda_low = 1'b0;
      tick(2);
      scl = 1'b1;
      tick(4);
      sda_low = 1'b1;
      tick(4);
      scl = 1'b0;
    end
  endtask
  task stop_c;
    begin
      tick(2);
      sda_low = 1'b1;
      tick(2);
      scl = 1'b1;
      tick(4);
      sda_low = 1'b0;
      tick(4);
    end
  endtask
  // eight bits MSB first, then ack slot released
  task wr(input [7:0] b, output ack);
    integer i;
    reg     s;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bit_io(b[i], s);
      bit_io(1'b1, ack);
    end
  endtask
  // read a byte, then answer with our ack bit
  task rd(input ak, output [7:0] b);
    integer i;
    reg     s;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bit_io(1'b1, b[i]);
      bit_io(ak, s);
    end
  endtask
endmodule // seti_host

/* File: seti_target_tb.sv */
// Self-checking bench for the serial EEPROM target interface
`timescale 1ns/1ps
module seti_target_tb;
  localparam [3:0]  TYPE = 4'h5;    // Arbitrary device type code
  localparam [16:0] WC   = 17'd200; // Shortened program time
  reg         sys_clk;
  reg         rst_n;
  reg         mem_ready;
  reg         write_inhibit_pin;
  reg  [2:0]  chip_select_straps;
  reg  [2:0]  sel;
  reg  [31:0] seed;
  reg  [15:0] base;
  reg         ak;
  integer     n_errors;
  integer     n_checks;
  integer     cyc;
  integer     i;
  wire        scl;
  wire        sda_low;
  wire        sda_out;
  wire        sda_oe;
  wire        mem_we;
  wire        prog_busy;
  wire [15:0] mem_addr;
  wire [7:0]  mem_wdata;
  reg  [7:0]  mem [0:65535];  // Array behind the memory port
  reg  [7:0]  expv [0:65535]; // Expected array contents
  wire [7:0]  mem_rdata = mem[mem_addr];
  // Open-drain wire with pull-up: low when either party pulls
  wire        sda = !(sda_low || sda_oe);
  seti_target #(.DEV_TYPE(TYPE), .WC_CYCLES(WC)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe),
    .chip_select_straps(chip_select_straps),
    .write_inhibit_pin(write_inhibit_pin), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_ready(mem_ready),
    .mem_rdata(mem_rdata), .prog_busy(prog_busy));
  seti_host u_host (.sys_clk(sys_clk), .sda(sda), .scl(scl),
    .sda_low(sda_low));
  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;
  // Memory takes writes; readiness wanders to stall the program walk
  always @(posedge sys_clk) if (mem_we) mem[mem_addr] <= mem_wdata;
  always @(negedge sys_clk) mem_ready <= (($random(seed) % 2) != 0);
  // Hang guard
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 80000) begin
      n_errors = n_errors + 1;
      print_verdict;
    end
  end
  task chk(input string what, input [15:0] e, input [15:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("wrong value %0s expected %h seen %h", what, e, g);
      end
    end
  endtask
  // Address word: type, straps, direction
  function [7:0] dw(input r);
    dw = {TYPE, sel, r};
  endfunction
  // Location of the i-th byte of a page write
  function [15:0] wrap_at(input [15:0] a, input integer k);
    wrap_at = {a[15:7], a[6:0] + k[6:0]};
  endfunction
  task hdr(input [7:0] w, output a);
    begin
      u_host.start_c;
      u_host.wr(w, a);
    end
  endtask
  task page_wr(input [15:0] a, input integer n);
    integer k;
    reg [7:0] d;
    begin
      hdr(dw(1'b0), ak);
      chk("dev ack", 0, ak);
      u_host.wr(a[15:8], ak);
      chk("hi ack", 0, ak);
      u_host.wr(a[7:0], ak);
      chk("lo ack", 0, ak);
      for (k = 0; k < n; k = k + 1) begin
        d = $random(seed);
        u_host.wr(d, ak);
        chk("data ack", {15'h0, write_inhibit_pin}, ak);
        if (!write_inhibit_pin) expv[wrap_at(a, k)] = d;
      end
      u_host.stop_c;
    end
  endtask
  task poll;
    integer t;
    begin
      hdr(dw(1'b0), ak);
      u_host.stop_c;
      chk("busy nack", 1, ak);
      for (t = 0; t < 20 && ak; t = t + 1) begin
        hdr(dw(1'b0), ak);
        u_host.stop_c;
      end
      chk("poll ack", 0, ak);
    end
  endtask
  task rd_seq(input [15:0] a, input integer n);
    integer k;
    reg [7:0] d;
    begin
      hdr(dw(1'b0), ak);
      u_host.wr(a[15:8], ak);
      u_host.wr(a[7:0], ak);
      hdr(dw(1'b1), ak);
      chk("read ack", 0, ak);
      for (k = 0; k < n; k = k + 1) begin
        u_host.rd(k == n - 1, d);
        chk("read data", expv[a + k[15:0]], d);
      end
      u_host.rd(1'b1, d);
      chk("released", 8'hff, d);
      u_host.stop_c;
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    seed = 32'h7f93;
    n_errors = 0;
    n_checks = 0;
    cyc = 0;
    rst_n = 1'b0;
    write_inhibit_pin = 1'b0;
    sel = $random(seed);
    chip_select_straps = sel;
    for (i = 0; i < 65536; i = i + 1) begin
      mem[i] = $random(seed);
      expv[i] = mem[i];
    end
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    base = $random(seed);
    page_wr({base[15:7], 7'h7a}, 10);
    poll;
    rd_seq({base[15:7], 7'h78}, 12);
    page_wr(base, 130);
    poll;
    rd_seq({base[15:7], 7'h00}, 128);
    write_inhibit_pin = 1'b1;
    page_wr(base ^ 16'h0080, 1);
    chk("no program", 0, prog_busy);
    rd_seq(base ^ 16'h0080, 2);
    write_inhibit_pin = 1'b0;
    rd_seq(16'hfffe, 4);
    for (i = 0; i < 3; i = i + 1) begin
      hdr(dw(1'b0) ^ (i == 0 ? 8'h10 : (i == 1 ? 8'h02 : 8'h09)), ak);
      u_host.stop_c;
      chk("foreign nack", 1, ak);
    end
    hdr(dw(1'b0), ak);
    u_host.wr(base[15:8], ak);
    u_host.wr(base[7:0], ak);
    for (i = 0; i < 4; i = i + 1) u_host.bit_io(1'b0, ak);
    u_host.stop_c;
    hdr(dw(1'b0), ak);
    u_host.stop_c;
    chk("partial idle", 0, ak);
    print_verdict;
  end
endmodule // seti_target_tb
bind seti_target seti_monitor #(.DEV_TYPE(DEV_TYPE), .WC_CYCLES(WC_CYCLES))
  u_mon (.sys_clk(sys_clk), .rst_n(rst_n), .scl(scl), .sda_out(sda_out),
  .sda_oe(sda_oe), .write_inhibit_pin(write_inhibit_pin), .mem_we(mem_we),
  .mem_ready(mem_ready), .prog_busy(prog_busy));
